// *** design/dcw_decoder.v ***
`timescale 1ns/1ps
`include "dcw_defines.vh"
module dcw_decoder #(
  parameter QUICK_STOP_CYCLES = `DCW_QUICK_STOP_CYCLES,
  parameter RAMP_STOP_CYCLES = `DCW_RAMP_STOP_CYCLES
) (
  input wire clk,
  input wire arst_n,
  input wire [1:0] profile_select,
  input wire cmd_write,
  input wire [31:0] cmd_data,
  input wire [31:0] ref_data,
  input wire [31:0] drive_status_in,
  input wire [31:0] drive_actual_in,
  input wire run_enable_from_fieldbus,
  input wire run_enable_ext,
  input wire ramp_in_from_fieldbus,
  input wire reset_from_fieldbus,
  input wire location_from_fieldbus,
  input wire fault_in,
  input wire at_setpoint,
  input wire adapter_comm_error,
  output reg [15:0] drive_command_word,
  output reg [31:0] native_cmd,
  output reg [31:0] native_ref,
  output reg [31:0] client_status,
  output reg [31:0] client_actual,
  output reg [2:0] drive_state,
  output reg coast_active,
  output reg ramp_output_zero,
  output reg ramp_hold,
  output reg ramp_input_zero,
  output reg run_enable,
  output reg control_location_select,
  output reg [3:0] free_bits
);

  // Fault latch, bit 7 history and the synchroniser stages.
  reg fault_reg;
  reg reset_bit_reg;
  reg comm_err_s1_reg;
  reg comm_err_reg;
  reg fault_s1_reg;
  reg fault_s2_reg;
  reg [15:0] timer_reg;
  // Combinational next values.
  reg [2:0] state_next;
  reg [15:0] status_next;
  // Decoded command bits and qualifiers.
  wire ramp_stop_n;
  wire coast_stop_n;
  wire quick_stop_n;
  wire remote;
  wire run_bit;
  wire reset_rise;
  wire conv;

  // State codes; they mirror the shared header so the bench can name them too.
  localparam [2:0] ST_INHIBIT = `DCW_ST_INHIBIT;
  localparam [2:0] ST_NOT_RDY = `DCW_ST_NOT_RDY;
  localparam [2:0] ST_RDY_ON = `DCW_ST_RDY_ON;
  localparam [2:0] ST_RDY_RUN = `DCW_ST_RDY_RUN;
  localparam [2:0] ST_OP_EN = `DCW_ST_OP_EN;
  localparam [2:0] ST_OFF1 = `DCW_ST_OFF1;
  localparam [2:0] ST_STOP23 = `DCW_ST_STOP23;
  localparam [2:0] ST_FAULT = `DCW_ST_FAULT;

  assign conv = (profile_select == `DCW_PROF_CONV);
  // The three stop bits always reach the drive, even without remote control.
  assign ramp_stop_n = drive_command_word[`DCW_CB_RAMP_STOP];
  assign coast_stop_n = drive_command_word[`DCW_CB_COAST_STOP];
  assign quick_stop_n = drive_command_word[`DCW_CB_QUICK_STOP];
  assign remote = drive_command_word[`DCW_CB_REMOTE];
  // Bit 3 alone gives run enable only when the fieldbus is its source; otherwise the external enable must be high too.
  // Without remote control bit 3 is ignored, so run enable drops with bit 10.
  assign run_bit = drive_command_word[`DCW_CB_RUN] & remote &
                   (run_enable_from_fieldbus ? 1'b1 : run_enable_ext);
  // Fault reset acts on a rising edge of bit 7 only.
  assign reset_rise = remote & reset_from_fieldbus &
                      drive_command_word[`DCW_CB_RESET] & ~reset_bit_reg;

  // Command register; bits 8 and 9 are stored and copied to native_cmd, but no control logic decodes them.
  // The delayed copy of bit 7 makes a steady high bit never repeat a reset.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_command_word <= `DCW_CMD_RESET;
      reset_bit_reg <= 1'b0;
    end else begin
      if (cmd_write) begin
        drive_command_word <= cmd_data[15:0];
      end
      reset_bit_reg <= drive_command_word[`DCW_CB_RESET];
    end
  end

  // Fault and comm error arrive from outside; two flip-flops each.
  // Only the second stage is read, so a metastable first stage never spreads.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_s1_reg <= 1'b0;
      fault_s2_reg <= 1'b0;
      comm_err_s1_reg <= 1'b0;
      comm_err_reg <= 1'b0;
    end else begin
      fault_s1_reg <= fault_in;
      fault_s2_reg <= fault_s1_reg;
      comm_err_s1_reg <= adapter_comm_error;
      comm_err_reg <= comm_err_s1_reg;
    end
  end

  // Next-state logic. Coast and quick stops are checked before the state case so they win.
  // A latched fault outranks even the stops: only a reset edge leaves it, and
  // the stop bits are read again from switch-on-inhibited on the next cycle.
  always @* begin
    state_next = drive_state;
    if (fault_reg) begin
      state_next = reset_rise ? ST_INHIBIT : ST_FAULT;
    end else if (!coast_stop_n || !quick_stop_n) begin
      // Both stops end in switch-on-inhibited, via their own stop state.
      // Only a running or ramping drive has a motor to stop, so only those
      // two states pass through the stop state; the rest drop straight down.
      if (drive_state == ST_OP_EN || drive_state == ST_OFF1) begin
        state_next = ST_STOP23;
      end else if (drive_state == ST_STOP23) begin
        // Coasting needs no wait; a quick stop waits out its stop time.
        if (!coast_stop_n || timer_reg == 16'h0000) begin
          state_next = ST_INHIBIT;
        end
      end else begin
        state_next = ST_INHIBIT;
      end
    end else begin
      case (drive_state)
        ST_INHIBIT: begin
          // Leaving inhibit needs bit 0 low first, so a word left high by an
          // earlier run cannot restart the motor by itself.
          if (!ramp_stop_n) state_next = ST_NOT_RDY;
        end
        ST_NOT_RDY: begin
          // One pass-through cycle so status shows the not-ready state once.
          state_next = ST_RDY_ON;
        end
        ST_RDY_ON: begin
          if (ramp_stop_n) state_next = ST_RDY_RUN;
        end
        ST_RDY_RUN: begin
          if (!ramp_stop_n) state_next = ST_RDY_ON;
          else if (run_bit) state_next = ST_OP_EN;
        end
        ST_OP_EN: begin
          if (!ramp_stop_n) state_next = ST_OFF1;
          else if (!run_bit) state_next = ST_RDY_RUN;
        end
        ST_OFF1: begin
          // The first stop holds until the ramp-down time has run out.
          if (timer_reg == 16'h0000) state_next = ST_RDY_ON;
        end
        ST_STOP23: begin
          // Reached here only once both stops are released again.
          state_next = ST_INHIBIT;
        end
        default: begin
          // The fault code, the only one not listed, falls back to the safe inhibited state.
          state_next = ST_INHIBIT;
        end
      endcase
    end
  end

  // State, fault latch and stop timer. A new fault wins over a reset edge.
  // The timer is shared because the two stop states are never active together.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_state <= ST_INHIBIT;
      fault_reg <= 1'b0;
      timer_reg <= 16'h0000;
    end else begin
      if (fault_s2_reg) begin
        // Set wins: a fault still present keeps the latch whatever bit 7 does.
        fault_reg <= 1'b1;
        drive_state <= ST_FAULT;
      end else begin
        if (reset_rise) fault_reg <= 1'b0;
        drive_state <= state_next;
      end
      // Load the stop time on entry to a stop state; then count down to zero.
      if (state_next == ST_OFF1 && drive_state != ST_OFF1) begin
        timer_reg <= RAMP_STOP_CYCLES;
      end else if (state_next == ST_STOP23 && drive_state != ST_STOP23) begin
        timer_reg <= QUICK_STOP_CYCLES;
      end else if (timer_reg != 16'h0000) begin
        timer_reg <= timer_reg - 16'h0001;
      end
    end
  end

  // Ramp controls and location, gated by remote; stops act regardless.
  // All of these are registered so the drive sees clean levels, at the cost
  // of one cycle of latency after the command word changes.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coast_active <= 1'b0;
      ramp_output_zero <= 1'b1;
      ramp_hold <= 1'b1;
      ramp_input_zero <= 1'b1;
      run_enable <= 1'b0;
      control_location_select <= 1'b0;
      free_bits <= 4'h0;
    end else begin
      coast_active <= ~coast_stop_n;
      ramp_output_zero <= ~remote | ~drive_command_word[`DCW_CB_RAMP_OUT] |
                          ~quick_stop_n | ~coast_stop_n;
      ramp_hold <= remote & ~drive_command_word[`DCW_CB_RAMP_HOLD];
      ramp_input_zero <= ramp_in_from_fieldbus &
                         (~remote | ~drive_command_word[`DCW_CB_RAMP_IN]);
      run_enable <= run_bit;
      // The location keeps its last choice while the fieldbus does not own it.
      if (remote && location_from_fieldbus) begin
        control_location_select <= drive_command_word[`DCW_CB_LOC];
      end
      free_bits <= drive_command_word[15:12];
    end
  end

  // Status word assembled from the state machine.
  // It is combinational here and registered once in the profile path below,
  // so the client sees a state change one cycle after the state register.
  always @* begin
    status_next = 16'h0000;
    // Readiness bits build up cumulatively as the drive nears operation.
    status_next[`DCW_SB_RDY_ON] = (drive_state == ST_RDY_ON) ||
                                  (drive_state == ST_RDY_RUN) ||
                                  (drive_state == ST_OP_EN);
    status_next[`DCW_SB_RDY_RUN] = (drive_state == ST_RDY_RUN) ||
                                   (drive_state == ST_OP_EN);
    status_next[`DCW_SB_RDY_REF] = (drive_state == ST_OP_EN);
    status_next[`DCW_SB_TRIPPED] = fault_reg;
    // Stop bits read high while the matching stop is released.
    status_next[`DCW_SB_COAST_OFF] = coast_stop_n;
    status_next[`DCW_SB_QUICK_OFF] = quick_stop_n;
    // Inhibit, setpoint and control-location flags.
    status_next[`DCW_SB_INHIB] = (drive_state == ST_INHIBIT);
    status_next[`DCW_SB_AT_SP] = at_setpoint & (drive_state == ST_OP_EN);
    status_next[`DCW_SB_REMOTE] = remote;
    status_next[`DCW_SB_LOC] = control_location_select;
    // Run enable and the adapter error come from registered sources only.
    status_next[`DCW_SB_RUN_EN] = run_enable;
    status_next[`DCW_SB_COMM_ERR] = comm_err_reg;
  end

  // Profile path: converted or untouched words in both directions.
  // Transparent modes copy every cycle and ignore the write strobe, so the
  // drive sees the client's words one cycle late and with no decoding.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      native_cmd <= 32'h00000000;
      native_ref <= 32'h00000000;
      client_status <= 32'h00000000;
      client_actual <= 32'h00000000;
    end else if (conv) begin
      native_cmd <= {16'h0000, drive_command_word};
      // Reference stays two's complement; gated off without remote control.
      native_ref <= remote ? {{16{ref_data[15]}}, ref_data[15:0]} :
                    32'h00000000;
      client_status <= {16'h0000, status_next};
      client_actual <= {16'h0000, drive_actual_in[15:0]};
    end else if (profile_select == `DCW_PROF_T16) begin
      // Only the low half travels; the upper half is held at zero.
      native_cmd <= {16'h0000, cmd_data[15:0]};
      native_ref <= {16'h0000, ref_data[15:0]};
      client_status <= {16'h0000, drive_status_in[15:0]};
      client_actual <= {16'h0000, drive_actual_in[15:0]};
    end else begin
      // Both codes above the 16-bit mode carry the full 32-bit words.
      native_cmd <= cmd_data;
      native_ref <= ref_data;
      client_status <= drive_status_in;
      client_actual <= drive_actual_in;
    end
  end

endmodule

// *** design/dcw_defines.vh ***
`ifndef DCW_DEFINES_VH
`define DCW_DEFINES_VH
// Profile selection codes.
`define DCW_PROF_CONV 2'h0
`define DCW_PROF_T16 2'h1
`define DCW_PROF_T32 2'h2
// Command word bit positions.
`define DCW_CB_RAMP_STOP 0
`define DCW_CB_COAST_STOP 1
`define DCW_CB_QUICK_STOP 2
`define DCW_CB_RUN 3
`define DCW_CB_RAMP_OUT 4
`define DCW_CB_RAMP_HOLD 5
`define DCW_CB_RAMP_IN 6
`define DCW_CB_RESET 7
`define DCW_CB_REMOTE 10
`define DCW_CB_LOC 11
// Status word bit positions.
`define DCW_SB_RDY_ON 0
`define DCW_SB_RDY_RUN 1
`define DCW_SB_RDY_REF 2
`define DCW_SB_TRIPPED 3
`define DCW_SB_COAST_OFF 4
`define DCW_SB_QUICK_OFF 5
`define DCW_SB_INHIB 6
`define DCW_SB_AT_SP 8
`define DCW_SB_REMOTE 9
`define DCW_SB_LOC 11
`define DCW_SB_RUN_EN 12
`define DCW_SB_COMM_ERR 15
// Reset values.
`define DCW_CMD_RESET 16'h0000
// Default stop times in clock cycles.
`define DCW_QUICK_STOP_CYCLES 16'h0100
`define DCW_RAMP_STOP_CYCLES 16'h0100
// Drive states.
`define DCW_ST_INHIBIT 3'h0
`define DCW_ST_NOT_RDY 3'h1
`define DCW_ST_RDY_ON 3'h2
`define DCW_ST_RDY_RUN 3'h3
`define DCW_ST_OP_EN 3'h4
`define DCW_ST_OFF1 3'h5
`define DCW_ST_STOP23 3'h6
`define DCW_ST_FAULT 3'h7
`endif

// *** test/dcw_decoder_sva.sv ***
`timescale 1ns/1ps
`include "dcw_defines.vh"
module dcw_decoder_sva (
  input wire clk,
  input wire arst_n,
  input wire [1:0] profile_select,
  input wire cmd_write,
  input wire [31:0] cmd_data,
  input wire [31:0] drive_status_in,
  input wire run_enable_from_fieldbus,
  input wire adapter_comm_error,
  input wire [15:0] drive_command_word,
  input wire [31:0] client_status,
  input wire [2:0] drive_state,
  input wire ramp_output_zero,
  input wire ramp_hold,
  input wire run_enable,
  input wire [3:0] free_bits
);
  // One clock domain, so clock and reset are given once for every property.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Slices taken apart so that the sampled-value functions see plain signals.
  wire [15:0] cmd_low;
  wire [3:0] word_free;
  wire word_run;
  assign cmd_low = cmd_data[15:0];
  assign word_free = drive_command_word[15:12];
  assign word_run = drive_command_word[3];
  a_word_load: assert property (cmd_write |=> drive_command_word == $past(cmd_low))
    else $error("command word not loaded");
  a_word_hold: assert property (!cmd_write |=> $stable(drive_command_word))
    else $error("command word changed without a write");
  a_free_bits: assert property (1'b1 |=> free_bits == $past(word_free))
    else $error("free bits do not follow the word");
  a_ramp_out: assert property (!drive_command_word[4] |=> ramp_output_zero)
    else $error("ramp output not forced to zero");
  a_ramp_hold: assert property (drive_command_word[10] && !drive_command_word[5] |=> ramp_hold)
    else $error("ramp output not held");
  a_run_enable: assert property (run_enable_from_fieldbus && drive_command_word[10] |=>
    run_enable == $past(word_run)) else $error("run enable wrong");
  a_coast_stop: assert property (!drive_command_word[1] && drive_state != `DCW_ST_FAULT |=>
    ##[0:2] (drive_state == `DCW_ST_STOP23 || drive_state == `DCW_ST_INHIBIT))
    else $error("coast stop not taken");
  a_comm_error: assert property ((profile_select == 2'h0 && adapter_comm_error) [*6] |->
    client_status[15]) else $error("comm error not reported");
  a_pass_status: assert property ((profile_select == 2'h2 && $stable(drive_status_in)) [*3] |->
    client_status == drive_status_in) else $error("status not passed through");
  // Main scenarios reached.
  c_op: cover property (drive_state == `DCW_ST_OP_EN);
  c_fault: cover property (drive_state == `DCW_ST_FAULT);
  c_stop: cover property (drive_state == `DCW_ST_STOP23);
endmodule

// *** test/dcw_client_model.sv ***
`timescale 1ns/1ps
module dcw_client_model (
  input wire clk,
  output reg cmd_write,
  output reg [31:0] cmd_data,
  output reg [31:0] ref_data
);
  // Idle client with nothing to send.
  initial begin
    cmd_write = 1'b0;
    cmd_data = 32'h0;
    ref_data = 32'h0;
  end
  // Word held across the taking edge; data is inverted once released so stale use shows.
  task send(input [31:0] d, input [15:0] r);
    begin
      @(negedge clk);
      cmd_write = 1'b1;
      cmd_data = d;
      ref_data = {{16{r[15]}}, r};
      @(negedge clk);
      cmd_write = 1'b0;
      cmd_data = ~d;
    end
  endtask
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
`include "dcw_defines.vh"
module tb;
  reg clk, arst_n, fault_in, adapter_comm_error, run_enable_ext;
  reg run_enable_from_fieldbus, ramp_in_from_fieldbus, reset_from_fieldbus, location_from_fieldbus;
  reg [1:0] profile_select;
  reg [31:0] drive_status_in, drive_actual_in, r, m;
  reg [15:0] f;
  reg tk = 1'b0;
  reg [15:0] exp_q[$];
  integer err_total = 0, n_tests = 0, i;
  wire cmd_write, coast_active, ramp_output_zero, ramp_hold, ramp_input_zero, run_enable;
  wire control_location_select;
  wire [31:0] cmd_data, ref_data, native_cmd, native_ref, client_status, client_actual;
  wire [15:0] drive_command_word;
  wire [2:0] drive_state;
  wire [3:0] free_bits;
  dcw_client_model u_dcw_client_model (.clk, .cmd_write, .cmd_data, .ref_data);
  // Short stop counts keep the run brief.
  dcw_decoder #(.QUICK_STOP_CYCLES(16'h0004), .RAMP_STOP_CYCLES(16'h0004)) u_dcw_decoder (
    .clk, .arst_n, .profile_select, .cmd_write, .cmd_data, .ref_data, .drive_status_in,
    .drive_actual_in, .run_enable_from_fieldbus, .run_enable_ext, .ramp_in_from_fieldbus,
    .reset_from_fieldbus, .location_from_fieldbus, .fault_in, .at_setpoint(1'b1),
    .adapter_comm_error, .drive_command_word, .native_cmd, .native_ref, .client_status,
    .client_actual, .drive_state, .coast_active, .ramp_output_zero, .ramp_hold,
    .ramp_input_zero, .run_enable, .control_location_select, .free_bits);
  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
      end
    end
  endtask
  task final_report;
    begin
      if (err_total == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task w(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // The expected word is noted before the client sends it.
  task wr(input [15:0] d);
    begin
      r = $urandom;
      exp_q.push_back(d);
      u_dcw_client_model.send({r[31:16], d}, r[15:0]);
    end
  endtask
  // Ready word, then the operating word with random free and ignored bits.
  task start;
    begin
      f = $urandom;
      wr(16'h047E);
      // From a running drive the first stop must time out before ready-on.
      w(8);
      chk(drive_state, `DCW_ST_RDY_ON);
      wr(16'h047F | (f & 16'hF300));
      w(4);
      chk(drive_state, `DCW_ST_OP_EN);
      chk(run_enable, 1'b1);
      chk(free_bits, f[15:12]);
      chk(client_status[2:0], 3'h7);
      chk(native_ref, ref_data);
    end
  endtask
  // A taken write shows in the command word one falling edge later.
  always @(posedge clk) tk <= cmd_write;
  always @(negedge clk) if (tk === 1'b1) chk(drive_command_word, exp_q.pop_front());
  // Cuts a hang short.
  initial begin
    #100000;
    err_total = err_total + 1;
    final_report;
  end
  // Main sequence.
  initial begin
    {arst_n, fault_in, adapter_comm_error, profile_select} = 5'h00;
    {run_enable_from_fieldbus, ramp_in_from_fieldbus} = 2'h3;
    run_enable_ext = 1'b1;
    {reset_from_fieldbus, location_from_fieldbus} = 2'h3;
    drive_status_in = 32'h0;
    drive_actual_in = 32'h0;
    r = $urandom(32'hE89D);
    repeat (16) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    chk(drive_command_word, 16'h0000);
    chk(ramp_output_zero, 1'b1);
    chk(drive_state, `DCW_ST_INHIBIT);
    start;
    for (i = 4; i < 7; i = i + 1) begin
      wr(16'h047F & ~(16'h0001 << i));
      w(4);
      chk(({ramp_input_zero, ramp_hold, ramp_output_zero} >> (i - 4)) & 1, 1);
    end
    wr(16'h0C7F);
    w(4);
    chk(control_location_select, 1'b1);
    wr(16'h047F);
    w(4);
    chk(control_location_select, 1'b0);
    start;
    wr(16'h047E);
    w(12);
    chk(drive_state, `DCW_ST_RDY_ON);
    start;
    wr(16'h047B);
    w(12);
    chk(drive_state, `DCW_ST_INHIBIT);
    start;
    wr(16'h007C);
    w(10);
    chk(drive_state, `DCW_ST_INHIBIT);
    chk(coast_active, 1'b1);
    start;
    fault_in = 1'b1;
    w(6);
    chk(drive_state, `DCW_ST_FAULT);
    fault_in = 1'b0;
    wr(16'h0400);
    w(4);
    chk(drive_state, `DCW_ST_FAULT);
    wr(16'h0480);
    w(4);
    chk(drive_state, `DCW_ST_INHIBIT);
    wr(16'h007E);
    w(4);
    wr(16'h007F);
    w(4);
    chk(drive_state == `DCW_ST_OP_EN, 1'b0);
    chk(native_ref, 32'h00000000);
    chk(native_cmd, 32'h0000007F);
    // External run enable source: bit 3 alone must not enable operation.
    run_enable_from_fieldbus = 1'b0;
    run_enable_ext = 1'b0;
    wr(16'h047F);
    w(4);
    chk(drive_state, `DCW_ST_RDY_RUN);
    chk(run_enable, 1'b0);
    run_enable_ext = 1'b1;
    w(4);
    chk(drive_state, `DCW_ST_OP_EN);
    run_enable_from_fieldbus = 1'b1;
    adapter_comm_error = 1'b1;
    w(6);
    chk(client_status[15], 1'b1);
    adapter_comm_error = 1'b0;
    w(6);
    chk(client_status[15], 1'b0);
    for (i = 1; i < 3; i = i + 1) begin
      profile_select = i[1:0];
      m = (i == 1) ? 32'h0000FFFF : 32'hFFFFFFFF;
      drive_status_in = $urandom;
      drive_actual_in = $urandom;
      wr(16'h0400);
      w(4);
      chk(client_status & m, drive_status_in & m);
      chk(client_actual & m, drive_actual_in & m);
      chk(native_ref & m, ref_data & m);
      chk(native_cmd & m, cmd_data & m);
    end
    final_report;
  end
endmodule
bind dcw_decoder dcw_decoder_sva u_dcw_decoder_sva (.clk, .arst_n, .profile_select, .cmd_write,
  .cmd_data, .drive_status_in, .run_enable_from_fieldbus, .adapter_comm_error,
  .drive_command_word, .client_status, .drive_state, .ramp_output_zero, .ramp_hold,
  .run_enable, .free_bits);
